//--- tb/eepc_checker.sv
// Purpose: Port-level checks for the EEPROM program/erase control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Tick checks hold only for divisors between 4 and 8
`timescale 1ns/100ps
module eepc_checker
    import eepc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Array side
    input wire eepc_array_type array_ctl,
    input wire logic tick_35us
);
    logic ctl_dphase;
    logic rd_dphase;

    // Marks data phases so causes can be traced back one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_dphase <= 1'b0;
            rd_dphase <= 1'b0;
        end else begin
            ctl_dphase <= hsel && hready && htrans[1] && hwrite
                && (haddr[17:0] == EEPC_ADDR_CONTROL);
            rd_dphase <= hsel && hready && htrans[1] && !hwrite;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_quiet3;
        !tick_35us [*3];
    endsequence

    a_tick_gap: assert property (tick_35us |=> s_quiet3)
        else $error("tick pulses closer than the divisor");
    a_tick_bound: assert property (tick_35us |-> ##[1:8] tick_35us)
        else $error("tick pulse missing");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    a_rdata_idle: assert property (!rd_dphase |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    a_pump_cause: assert property ($rose(array_ctl.pump_on) |->
        $past(ctl_dphase) && $past(hwdata[EEPC_CTL_ENABLE]))
        else $error("pump switched on without an enable write");
    a_off_cause: assert property ($rose(array_ctl.array_off) |->
        $past(ctl_dphase) && $past(hwdata[EEPC_CTL_POWER_OFF]))
        else $error("array switched off without a control write");
    a_op_frozen: assert property (array_ctl.pump_on && $past(array_ctl.pump_on)
        |-> $stable(array_ctl.op))
        else $error("operation changed while pump on");
endmodule : eepc_checker

//--- tb/eepc_top_test.sv
// Purpose: Register-level tests of the EEPROM program/erase control block
// Assumes: Divider clocked from the bus clock, divisor 4 from the options
// Notes: Oscillator tick is tied off; monitor inputs are driven by the tests
`timescale 1ns/100ps
module eepc_top_test
    import eepc_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, tick_35us;
    logic monitor_mode, monitor_code_ok;
    logic [31:0] haddr, hwdata, hrdata, rd_val;
    logic [1:0] htrans;
    logic [2:0] hsize;
    eepc_array_type array_ctl;
    int err_total, n_tests, n;
    logic [17:0] ro_addr [4] = '{EEPC_ADDR_OPTION_B, EEPC_ADDR_DIV_OPT_HIGH,
        EEPC_ADDR_DIV_OPT_LOW, EEPC_ADDR_ARRAY_CONFIG};
    logic [31:0] ro_val [4] = '{32'h0A, 32'h80, 32'h04, 32'h10};

    assign hready = hreadyout;

    eepc_top #(.OPTION_B(8'h0A), .DIV_OPTION_HIGH(8'h80), .DIV_OPTION_LOW(8'h04)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_clock_tick(1'b0),
        .monitor_mode(monitor_mode), .monitor_code_ok(monitor_code_ok), .array_ctl(array_ctl),
        .tick_35us(tick_35us));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Single word transfer; read data is taken at the edge ending the data phase
    task xfer(input logic wr, input logic [17:0] addr, input logic [31:0] wdata);
        hsel <= 1'b1;
        haddr <= {14'h0000, addr};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd_val = hrdata;
    endtask : xfer

    task rchk(input logic [17:0] addr, input logic [31:0] exp);
        xfer(1'b0, addr, 32'h0);
        chk(rd_val, exp);
    endtask : rchk

    // Skips one gap so a divisor change mid-count is not measured
    task tick_gap;
        @(posedge hclk iff tick_35us === 1'b1);
        @(posedge hclk iff tick_35us === 1'b1);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (tick_35us !== 1'b1 && n < 50);
    endtask : tick_gap

    // Polls the enable bit until the auto timer clears it
    task poll_enable;
        n = 0;
        do begin
            xfer(1'b0, EEPC_ADDR_CONTROL, 32'h0);
            n++;
        end while (rd_val[0] === 1'b1 && n < 200);
    endtask : poll_enable

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        monitor_mode = 1'b0;
        monitor_code_ok = 1'b0;
        err_total = 0;
        n_tests = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(EEPC_ADDR_CONTROL, 32'h0);
        rchk(EEPC_ADDR_DIV_HIGH, 32'h80);
        rchk(EEPC_ADDR_DIV_LOW, 32'h04);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, ro_addr[i], 32'hFF);
            rchk(ro_addr[i], ro_val[i]);
        end
        xfer(1'b1, 18'h00060, 32'hFF);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h80);
        rchk(EEPC_ADDR_CONTROL, 32'h80);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, EEPC_ADDR_CONTROL, {26'h0, i[1:0], 4'h0});
            rchk(EEPC_ADDR_CONTROL, {26'h0, i[1:0], 4'h0});
            chk({30'h0, array_ctl.op}, {30'h0, i[1:0]});
        end
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h40);
        rchk(EEPC_ADDR_CONTROL, 32'h40);
        chk({31'h0, array_ctl.array_off}, 32'h1);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h01);
        rchk(EEPC_ADDR_CONTROL, 32'h00);
        chk({31'h0, array_ctl.array_off}, 32'h0);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h08);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h09);
        rchk(EEPC_ADDR_CONTROL, 32'h08);
        xfer(1'b1, EEPC_ADDR_DIV_LOW, 32'h06);
        rchk(EEPC_ADDR_DIV_LOW, 32'h04);
        xfer(1'b1, 18'h00800, 32'h5A);
        xfer(1'b1, 18'h00985, 32'hA5);
        rchk(EEPC_ADDR_CAPTURE, 32'h01A50985);
        chk({array_ctl.addr, 8'h00, array_ctl.data}, 32'h098500A5);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h09);
        rchk(EEPC_ADDR_CONTROL, 32'h09);
        chk({31'h0, array_ctl.pump_on}, 32'h1);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h11);
        rchk(EEPC_ADDR_CONTROL, 32'h09);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h00);
        rchk(EEPC_ADDR_CONTROL, 32'h08);
        chk({31'h0, array_ctl.pump_on}, 32'h0);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h00);
        rchk(EEPC_ADDR_CONTROL, 32'h00);
        // Auto-terminated program of one byte
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h08);
        xfer(1'b1, 18'h00810, 32'h00);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h0B);
        poll_enable();
        chk(rd_val, 32'h0A);
        chk(32'(n >= 28), 32'h1);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h00);
        tick_gap();
        chk(n, 32'd4);
        xfer(1'b1, EEPC_ADDR_DIV_LOW, 32'h06);
        rchk(EEPC_ADDR_DIV_LOW, 32'h06);
        tick_gap();
        chk(n, 32'd6);
        xfer(1'b1, EEPC_ADDR_DIV_HIGH, 32'h00);
        rchk(EEPC_ADDR_DIV_HIGH, 32'h00);
        xfer(1'b1, EEPC_ADDR_DIV_HIGH, 32'h81);
        rchk(EEPC_ADDR_DIV_HIGH, 32'h00);
        xfer(1'b1, EEPC_ADDR_DIV_LOW, 32'h04);
        rchk(EEPC_ADDR_DIV_LOW, 32'h06);
        // Byte erase of the config byte, then a capture in a now protected block
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h18);
        xfer(1'b1, EEPC_ADDR_NV_CONFIG, 32'h00);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h1B);
        poll_enable();
        chk(rd_val, 32'h1A);
        rchk(EEPC_ADDR_NV_CONFIG, 32'hFF);
        rchk(EEPC_ADDR_ARRAY_CONFIG, 32'hFF);
        xfer(1'b1, 18'h00900, 32'h33);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h19);
        rchk(EEPC_ADDR_CONTROL, 32'h19);
        chk({31'h0, array_ctl.pump_on}, 32'h0);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h00);
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h00);
        // Monitor mode without the code keeps writes out of the latch
        monitor_mode <= 1'b1;
        xfer(1'b1, EEPC_ADDR_CONTROL, 32'h08);
        xfer(1'b1, 18'h00900, 32'h44);
        rchk(EEPC_ADDR_CAPTURE, 32'h00330900);
        rchk(EEPC_ADDR_STATUS, 32'h10);
        monitor_code_ok <= 1'b1;
        xfer(1'b1, 18'h00900, 32'h44);
        rchk(EEPC_ADDR_CAPTURE, 32'h01440900);
        print_verdict();
    end

    // The whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge hclk);
        err_total++;
        print_verdict();
    end
endmodule : eepc_top_test

bind eepc_top eepc_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .array_ctl(array_ctl),
    .tick_35us(tick_35us));

//--- verilog/eepc_pkg.sv
// Purpose: Constants and types for the EEPROM program/erase control block
// Assumes: AHB-Lite register access, 32-bit data, one register per word
// Notes: Option values are hard-wired parameters of the top module
package eepc_pkg;
    // Option and config locations are word indices; the bus byte address is four times that
    localparam logic [15:0] EEPC_IDX_OPTION_B = 16'h003F;
    localparam logic [15:0] EEPC_IDX_DIV_OPT_HIGH = 16'hFE10;
    localparam logic [15:0] EEPC_IDX_DIV_OPT_LOW = 16'hFE11;
    localparam logic [15:0] EEPC_IDX_NV_CONFIG = 16'hFE1C;
    // Register byte addresses
    localparam logic [17:0] EEPC_ADDR_OPTION_B = {EEPC_IDX_OPTION_B, 2'b00};
    localparam logic [17:0] EEPC_ADDR_DIV_OPT_HIGH = {EEPC_IDX_DIV_OPT_HIGH, 2'b00};
    localparam logic [17:0] EEPC_ADDR_DIV_OPT_LOW = {EEPC_IDX_DIV_OPT_LOW, 2'b00};
    localparam logic [17:0] EEPC_ADDR_NV_CONFIG = {EEPC_IDX_NV_CONFIG, 2'b00};
    localparam logic [17:0] EEPC_ADDR_CONTROL = 18'h00040;
    localparam logic [17:0] EEPC_ADDR_ARRAY_CONFIG = 18'h00044;
    localparam logic [17:0] EEPC_ADDR_DIV_HIGH = 18'h00048;
    localparam logic [17:0] EEPC_ADDR_DIV_LOW = 18'h0004C;
    localparam logic [17:0] EEPC_ADDR_CAPTURE = 18'h00050;
    localparam logic [17:0] EEPC_ADDR_STATUS = 18'h00054;
    localparam logic [17:0] EEPC_ADDR_MONITOR = 18'h00058;
    // Array window
    localparam logic [15:0] EEPC_ARRAY_BASE = 16'h0800;
    localparam logic [15:0] EEPC_ARRAY_LAST = 16'h09FF;
    localparam int EEPC_BLOCK_SHIFT = 7;
    // Control register bit positions
    localparam int EEPC_CTL_SPARE = 7;
    localparam int EEPC_CTL_POWER_OFF = 6;
    localparam int EEPC_CTL_OP_HIGH = 5;
    localparam int EEPC_CTL_OP_LOW = 4;
    localparam int EEPC_CTL_LATCH = 3;
    localparam int EEPC_CTL_AUTO = 1;
    localparam int EEPC_CTL_ENABLE = 0;
    // Array configuration and divider high register layout
    localparam int EEPC_CFG_PROTECT = 4;
    localparam int EEPC_DIV_SECD = 7;
    // Option byte B bit positions
    localparam int EEPC_OPT_DIV_CLK = 3;
    localparam int EEPC_OPT_SEC = 2;
    localparam int EEPC_OPT_MON_SEC = 1;
    // Reset values
    localparam logic [7:0] EEPC_NV_CONFIG_RESET = 8'h10;
    // Pulse lengths in 35 us ticks
    localparam logic [7:0] EEPC_TICKS_PROGRAM = 8'h10;
    localparam logic [7:0] EEPC_TICKS_BYTE_ERASE = 8'h10;
    localparam logic [7:0] EEPC_TICKS_BLOCK_ERASE = 8'h20;
    localparam logic [7:0] EEPC_TICKS_BULK_ERASE = 8'h40;

    typedef enum logic [1:0] {
        EEPC_OP_BYTE_PROGRAM = 2'b00,
        EEPC_OP_BYTE_ERASE = 2'b01,
        EEPC_OP_BLOCK_ERASE = 2'b10,
        EEPC_OP_BULK_ERASE = 2'b11
    } eepc_op_type;

    typedef enum logic [1:0] {
        EEPC_IDLE = 2'b00,
        EEPC_PULSE = 2'b01,
        EEPC_DONE = 2'b10
    } eepc_phase_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [17:0] addr;
    } eepc_req_type;

    typedef struct packed {
        logic spare;
        logic power_off;
        eepc_op_type op;
        logic latch;
        logic auto_end;
        logic enable;
    } eepc_ctl_type;

    typedef struct packed {
        logic pump_on;
        logic array_off;
        logic array_blocked;
        eepc_op_type op;
        logic [15:0] addr;
        logic [7:0] data;
    } eepc_array_type;

    typedef struct packed {
        eepc_req_type req;
        eepc_ctl_type ctl;
        logic [7:0] acfg;
        logic [7:0] nv_cfg;
        logic [10:0] divisor;
        logic div_secd;
        logic [15:0] cap_addr;
        logic [7:0] cap_data;
        logic cap_valid;
        logic [10:0] div_count;
        logic [7:0] tick_count;
        eepc_phase_type phase;
        logic done_flag;
        logic [31:0] rdata;
        logic [1:0] mon_sync;
        logic mon_unlock;
    } eepc_state_type;
endpackage : eepc_pkg

//--- verilog/eepc_top.sv
// Purpose: EEPROM program/erase control registers and timebase, AHB-Lite slave
// Assumes: Single whole-word transfers; zero wait states; response always OKAY
// Notes: Array writes land in the capture latch; pump and array pins drive the macro
// Notes on behaviour
// RULE1: Power-off bit disables array; reset clears it
// RULE2: Operation select picks program, byte/block/bulk erase
// RULE3: Block-protect bit blocks program/erase in block
// RULE4: Latch bit captures array write address and data
// RULE5: Latch clear ignored while enable set
// RULE6: Clearing both clears only enable bit
// RULE7: Auto mode clears enable when timer ends
// RULE8: Pump on only with latch and capture
// RULE9: Reset clears enable, power, select, latch
// RULE10: Array configuration read-only, loaded from config byte
// RULE11: Protection bit matters only with security option
// RULE12: Config byte programmed like ordinary array byte
// RULE13: Divide reference by 11-bit divisor for tick
// RULE14: Divider registers load from option bytes
// RULE15: Security-disable zero locks divider registers
// RULE16: Divisor readable; writable only unlatched, unlocked
// RULE17: Software picks divisor from reference frequency
// RULE18: Clock-select option picks bus or oscillator clock
// RULE19: Security follows config protect bit when enabled
// RULE20: Monitor security blocks array without code
// RULE21: Option registers are read-only constants
// RULE22: Spare bit is plain storage
// RULE23: Enable refused without latch and valid capture
// RULE24: Later captures overwrite earlier ones
// RULE25: Block protect updates on reset or config read
// RULE26: Auto timer counts 35 us ticks
`timescale 1ns/100ps
module eepc_top
    import eepc_pkg::*;
#(
    parameter logic [7:0] OPTION_B = 8'h00,
    parameter logic [7:0] DIV_OPTION_HIGH = 8'h80,
    parameter logic [7:0] DIV_OPTION_LOW = 8'h8C
) (
    // Bus clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Chip context
    input wire logic osc_clock_tick,
    input wire logic monitor_mode,
    input wire logic monitor_code_ok,
    // Array macro control
    output eepc_array_type array_ctl,
    output logic tick_35us
);
    eepc_state_type s;
    eepc_state_type next_s;

    logic [17:0] a;
    logic in_array;
    logic in_nv;
    logic [1:0] blk;
    logic blk_protected;
    logic security_on;
    logic access_blocked;
    logic [7:0] wbyte;
    logic [7:0] next_ctl_bits;
    logic div_unlock;
    logic ref_tick;
    logic [7:0] pulse_len;

    assign a = s.req.addr;
    assign wbyte = hwdata[7:0];
    assign in_array = (a[17:16] == 2'b00) && (a[15:0] >= EEPC_ARRAY_BASE)
        && (a[15:0] <= EEPC_ARRAY_LAST);
    // Config byte is a valid target for the same latch sequence
    assign in_nv = (a == EEPC_ADDR_NV_CONFIG); // RULE12
    assign blk = 2'(16'(a[15:0] - EEPC_ARRAY_BASE) >> EEPC_BLOCK_SHIFT);
    assign blk_protected = in_array && s.acfg[blk]; // RULE3
    assign security_on = OPTION_B[EEPC_OPT_SEC] && !s.acfg[EEPC_CFG_PROTECT]; // RULE11 RULE19
    // Monitor mode is taken from another domain, hence the synchroniser
    assign access_blocked = OPTION_B[EEPC_OPT_MON_SEC] && s.mon_sync[1]
        && !s.mon_unlock; // RULE20
    assign div_unlock = !s.ctl.latch && s.div_secd; // RULE15 RULE16
    // Bus clock when option is 1, else oscillator enable pulse
    assign ref_tick = OPTION_B[EEPC_OPT_DIV_CLK] ? 1'b1 : osc_clock_tick; // RULE18

    always_comb begin
        case (s.ctl.op)
            EEPC_OP_BYTE_PROGRAM: pulse_len = EEPC_TICKS_PROGRAM;
            EEPC_OP_BYTE_ERASE: pulse_len = EEPC_TICKS_BYTE_ERASE;
            EEPC_OP_BLOCK_ERASE: pulse_len = EEPC_TICKS_BLOCK_ERASE;
            default: pulse_len = EEPC_TICKS_BULK_ERASE;
        endcase
    end

    always_comb begin
        next_s = s;
        next_ctl_bits = wbyte;
        next_s.done_flag = s.done_flag;
        // Address phase capture
        next_s.req.valid = hsel && hready && htrans[1];
        next_s.req.write = hwrite;
        next_s.req.addr = haddr[17:0];
        next_s.mon_sync = {s.mon_sync[0], monitor_mode};
        if (!s.mon_sync[1]) begin
            next_s.mon_unlock = 1'b0;
        end else if (monitor_code_ok) begin
            next_s.mon_unlock = 1'b1;
        end
        // Timebase divider
        next_s.tick_count = s.tick_count;
        if (ref_tick) begin
            if (s.div_count + 11'h001 >= s.divisor) begin
                next_s.div_count = 11'h000; // RULE13
            end else begin
                next_s.div_count = 11'(s.div_count + 11'h001);
            end
        end
        // Pulse timer
        case (s.phase)
            EEPC_IDLE: begin
                if (s.ctl.enable) begin
                    next_s.phase = EEPC_PULSE;
                    next_s.tick_count = 8'h00;
                end
            end
            EEPC_PULSE: begin
                if (!s.ctl.enable) begin
                    next_s.phase = EEPC_IDLE;
                end else if (tick_35us) begin
                    next_s.tick_count = 8'(s.tick_count + 8'h01); // RULE26
                    if (8'(s.tick_count + 8'h01) >= pulse_len) begin
                        next_s.phase = EEPC_DONE;
                    end
                end
            end
            EEPC_DONE: begin
                if (s.ctl.auto_end) begin
                    next_s.ctl.enable = 1'b0; // RULE7
                    next_s.done_flag = 1'b1;
                end
                if (!s.ctl.enable || s.ctl.auto_end) begin
                    next_s.phase = EEPC_IDLE;
                end
            end
            default: next_s.phase = EEPC_IDLE;
        endcase
        // Data phase
        next_s.rdata = 32'h0000_0000;
        if (s.req.valid && s.req.write) begin
            if ((in_array || in_nv) && s.ctl.latch && !access_blocked) begin
                // Config byte is held by its index so it fits the array address field
                next_s.cap_addr = in_nv ? EEPC_IDX_NV_CONFIG : a[15:0]; // RULE4 RULE24
                next_s.cap_data = wbyte;
                next_s.cap_valid = 1'b1;
            end
            case (a)
                EEPC_ADDR_CONTROL: begin
                    next_s.ctl.spare = next_ctl_bits[EEPC_CTL_SPARE]; // RULE22
                    next_s.ctl.power_off = next_ctl_bits[EEPC_CTL_POWER_OFF]; // RULE1
                    // Mode is frozen while the pump runs
                    if (!s.ctl.enable) begin
                        next_s.ctl.op = eepc_op_type'(wbyte[EEPC_CTL_OP_HIGH:EEPC_CTL_OP_LOW]);
                    end
                    next_s.ctl.auto_end = wbyte[EEPC_CTL_AUTO];
                    if (wbyte[EEPC_CTL_LATCH] || !s.ctl.enable) begin
                        next_s.ctl.latch = wbyte[EEPC_CTL_LATCH]; // RULE5 RULE6
                    end
                    if (!wbyte[EEPC_CTL_LATCH]) begin
                        next_s.cap_valid = s.ctl.enable ? s.cap_valid : 1'b0;
                    end
                    if (!wbyte[EEPC_CTL_ENABLE]) begin
                        next_s.ctl.enable = 1'b0;
                    end else if (s.ctl.latch && s.cap_valid) begin
                        next_s.ctl.enable = 1'b1; // RULE23
                    end
                    // Completion in the same cycle wins over the clear
                    if (wbyte[EEPC_CTL_ENABLE] && s.phase != EEPC_DONE) begin
                        next_s.done_flag = 1'b0;
                    end
                end
                EEPC_ADDR_DIV_HIGH: begin
                    if (div_unlock) begin
                        next_s.div_secd = wbyte[EEPC_DIV_SECD];
                        next_s.divisor[10:8] = wbyte[2:0];
                    end
                end
                EEPC_ADDR_DIV_LOW: begin
                    if (div_unlock) begin
                        next_s.divisor[7:0] = wbyte;
                    end
                end
                default: begin
                end
            endcase
        end
        // Config byte program/erase completes when the pulse ends
        if (s.phase == EEPC_DONE && s.cap_addr == EEPC_IDX_NV_CONFIG) begin
            if (s.ctl.op == EEPC_OP_BYTE_PROGRAM) begin
                next_s.nv_cfg = s.nv_cfg & s.cap_data; // RULE12
            end else if (s.ctl.op == EEPC_OP_BYTE_ERASE) begin
                next_s.nv_cfg = 8'hFF;
            end
        end
        // Read data is launched in the address phase so it stands in the data phase;
        // it looks at next_s so a write whose data phase ends now is already seen
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[17:0])
                EEPC_ADDR_OPTION_B: next_s.rdata[7:0] = OPTION_B; // RULE21
                EEPC_ADDR_DIV_OPT_HIGH: next_s.rdata[7:0] = DIV_OPTION_HIGH;
                EEPC_ADDR_DIV_OPT_LOW: next_s.rdata[7:0] = DIV_OPTION_LOW;
                EEPC_ADDR_NV_CONFIG: begin
                    next_s.rdata[7:0] = next_s.nv_cfg;
                    next_s.acfg = next_s.nv_cfg; // RULE25
                end
                EEPC_ADDR_CONTROL: next_s.rdata[7:0] = {next_s.ctl.spare,
                    next_s.ctl.power_off, next_s.ctl.op, next_s.ctl.latch, 1'b0,
                    next_s.ctl.auto_end, next_s.ctl.enable};
                EEPC_ADDR_ARRAY_CONFIG: next_s.rdata[7:0] = next_s.acfg; // RULE10
                EEPC_ADDR_DIV_HIGH: next_s.rdata[7:0] = {next_s.div_secd, 4'h0,
                    next_s.divisor[10:8]};
                EEPC_ADDR_DIV_LOW: next_s.rdata[7:0] = next_s.divisor[7:0]; // RULE16
                EEPC_ADDR_CAPTURE: next_s.rdata = {7'h00, next_s.cap_valid,
                    next_s.cap_data, next_s.cap_addr};
                EEPC_ADDR_STATUS: next_s.rdata = {27'h0, access_blocked, security_on,
                    next_s.done_flag, next_s.phase};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0; // RULE9
            s.acfg <= EEPC_NV_CONFIG_RESET; // RULE10
            s.nv_cfg <= EEPC_NV_CONFIG_RESET;
            s.divisor <= {DIV_OPTION_HIGH[2:0], DIV_OPTION_LOW}; // RULE14
            s.div_secd <= DIV_OPTION_HIGH[EEPC_DIV_SECD];
        end else begin
            s <= next_s;
        end
    end

    assign tick_35us = ref_tick && (s.div_count + 11'h001 >= s.divisor);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;

    always_comb begin
        array_ctl.pump_on = s.ctl.enable && s.ctl.latch && s.cap_valid
            && !blk_protected && !access_blocked; // RULE8 RULE3
        if (s.cap_addr >= EEPC_ARRAY_BASE && s.cap_addr <= EEPC_ARRAY_LAST) begin
            array_ctl.pump_on = array_ctl.pump_on
                && !s.acfg[2'(16'(s.cap_addr - EEPC_ARRAY_BASE) >> EEPC_BLOCK_SHIFT)];
        end
        array_ctl.array_off = s.ctl.power_off; // RULE1
        array_ctl.array_blocked = access_blocked;
        array_ctl.op = s.ctl.op; // RULE2
        array_ctl.addr = s.cap_addr;
        array_ctl.data = s.cap_data;
    end
endmodule : eepc_top
